// ### shared/amr_pkg.sv
// Package: constants and carrier structs for alarm mask and auto-retry block
// Operation
// - Mask bits: cycle, low current, break, feedback, error
// - Light alarm only where mask bit is one
// - Minor fault output on while light alarm
// - Light alarm never trips the drive
// - Eligible trip reset automatically when retry enabled
// - Retry mask uses same seven bit positions
// - Retry limit 1 to 10, zero disables
// - Exceeding limit latches alarm, stops retries
// - Wait retry interval after trip, then reset
// - Five alarm-free minutes clear retry counter
// - Break detection only with current input feedback
// - Break when current below programmed threshold
// - Break time zero disables, else persist time
// - Preset write loads run-time counter
// - Run-time preset held in hexadecimal
package amr_pkg;

  // ****************************************
  // Factor bit positions
  // ****************************************
  localparam int FB_OVER_CYCLE  = 0;
  localparam int FB_LOW_CURRENT = 1;
  localparam int FB_WIRE_BREAK  = 2;
  localparam int FB_FEEDBACK1   = 3;
  localparam int FB_FEEDBACK2   = 4;
  localparam int FB_EXCESS_ERR1 = 5;
  localparam int FB_EXCESS_ERR2 = 6;
  localparam int FACTOR_W       = 7;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ            = 125_000_000;
  localparam int TICK_MS           = 100;
  localparam int TICK_CYCLES       = CLK_HZ / 1000 * TICK_MS;
  localparam int QUIET_MINUTES     = 5;
  localparam int QUIET_TICKS       = QUIET_MINUTES * 60 * 1000 / TICK_MS;
  localparam int OUTPUT_CODE_LALM  = 98;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0]  RST_RETRY_CNT = 4'h0;
  localparam logic [31:0] RST_RUNTIME   = 32'h0000_0000;

  typedef enum logic [1:0] {
    AMR_IDLE    = 2'b00,
    AMR_TRIPPED = 2'b01,
    AMR_WAIT    = 2'b10,
    AMR_LOCKED  = 2'b11
  } amr_state_e;

  // Settings as held by the controller; times in 0.1 units
  typedef struct packed {
    logic [6:0]  light_alarm_factor_mask;
    logic [6:0]  retry_factor_mask;
    logic [3:0]  retry_count_limit;
    logic [12:0] retry_wait_interval;
    logic [7:0]  break_current_threshold;
    logic [9:0]  break_detect_time;
  } amr_cfg_s;

  typedef struct packed {
    amr_state_e  state;
    logic [6:0]  fault_latch;
    logic [3:0]  retry_cnt;
    logic [12:0] wait_ticks;
    logic [12:0] quiet_ticks;
    logic [9:0]  break_ticks;
    logic        feedback_break_alarm;
    logic        minor_fault_output;
    logic        trip_reset;
    logic        locked_alarm;
    logic [31:0] runtime;
    logic [29:0] run_ms_div;
    logic [23:0] tick_div;
  } amr_state_s;

endpackage : amr_pkg

// ### src/amr_alarm_retry.sv
// Module: light alarm masking, auto-retry, wire-break detect, run-time counter
`timescale 1ns/1ps
`default_nettype none
module amr_alarm_retry #(
  parameter int TICK_CYCLES = amr_pkg::TICK_CYCLES,
  parameter int QUIET_TICKS = amr_pkg::QUIET_TICKS,
  parameter int HOUR_TICKS  = 36000
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire amr_pkg::amr_cfg_s cfg,
  input  wire logic [6:0]        fault_in,
  input  wire logic              current_input_terminal,
  input  wire logic [7:0]        current_level,
  input  wire logic              motor_running,
  input  wire logic [7:0]        dout_assign_code,
  input  wire logic              runtime_preset_we,
  input  wire logic [31:0]       runtime_preset,
  output logic                   minor_fault_output,
  output logic                   dout_terminal,
  output logic                   tripped,
  output logic                   trip_reset,
  output logic                   locked_alarm,
  output logic                   feedback_break_alarm,
  output logic [3:0]             retry_count,
  output logic [31:0]            runtime_hours
);

  initial begin
    // Counters are 24, 13 and 30 bits wide; larger settings would wrap
    if (TICK_CYCLES < 2 || TICK_CYCLES > 16777216 || QUIET_TICKS < 1
        || QUIET_TICKS > 8191 || HOUR_TICKS < 1 || HOUR_TICKS > 1073741823) begin
      $error("amr_alarm_retry: parameter out of range");
    end
  end

  amr_pkg::amr_state_s st;
  amr_pkg::amr_state_s next_st;
  logic [6:0]          all_faults;
  logic                tick;
  logic                light_present;
  logic                trip_req;
  logic                retry_ok;
  logic [12:0]         wait_eff;

  // Wire-break joins the external faults in its own bit
  always_comb begin
    all_faults = fault_in;
    all_faults[amr_pkg::FB_WIRE_BREAK] = fault_in[amr_pkg::FB_WIRE_BREAK]
                                         | st.feedback_break_alarm;
  end

  assign tick          = (st.tick_div == 24'(TICK_CYCLES - 1));
  assign light_present = |(all_faults & cfg.light_alarm_factor_mask);
  // Unselected factors trip; selected ones keep running
  assign trip_req      = |(all_faults & ~cfg.light_alarm_factor_mask);
  // Retry needs eligible factor, nonzero limit and room left
  assign retry_ok      = (cfg.retry_count_limit != 4'h0)
                       && (cfg.retry_count_limit <= 4'hA)
                       && ((st.fault_latch & cfg.retry_factor_mask
                            & ~cfg.light_alarm_factor_mask) != 7'h00)
                       && (st.retry_cnt < cfg.retry_count_limit);
  // Interval floor of 0.5 s (5 ticks)
  assign wait_eff      = (cfg.retry_wait_interval < 13'h0005) ? 13'h0005
                                                              : cfg.retry_wait_interval;

  always_comb begin
    next_st            = st;
    next_st.trip_reset = 1'b0;
    next_st.tick_div   = tick ? 24'h000000 : st.tick_div + 24'h000001;

    // ****************************************
    // Wire-break detection
    // ****************************************
    if (!current_input_terminal || cfg.break_detect_time == 10'h000) begin
      next_st.break_ticks          = 10'h000;
      next_st.feedback_break_alarm = 1'b0;
    end else if (current_level < cfg.break_current_threshold) begin
      if (tick && st.break_ticks != cfg.break_detect_time) begin
        next_st.break_ticks = st.break_ticks + 10'h001;
      end
      if (st.break_ticks == cfg.break_detect_time) begin
        next_st.feedback_break_alarm = 1'b1;
      end
    end else begin
      next_st.break_ticks          = 10'h000;
      next_st.feedback_break_alarm = 1'b0;
    end

    next_st.minor_fault_output = light_present;

    // ****************************************
    // Trip and auto-retry sequencer
    // ****************************************
    case (st.state)
      amr_pkg::AMR_IDLE: begin
        if (trip_req) begin
          next_st.state       = amr_pkg::AMR_TRIPPED;
          next_st.fault_latch = all_faults & ~cfg.light_alarm_factor_mask;
        end
      end
      amr_pkg::AMR_TRIPPED: begin
        next_st.wait_ticks = 13'h0000;
        if (retry_ok) begin
          next_st.state = amr_pkg::AMR_WAIT;
        end else begin
          next_st.state        = amr_pkg::AMR_LOCKED;
          next_st.locked_alarm = (cfg.retry_count_limit != 4'h0);
        end
      end
      amr_pkg::AMR_WAIT: begin
        if (tick) begin
          next_st.wait_ticks = st.wait_ticks + 13'h0001;
        end
        if (st.wait_ticks >= wait_eff) begin
          next_st.trip_reset  = 1'b1;
          next_st.retry_cnt   = st.retry_cnt + 4'h1;
          next_st.fault_latch = 7'h00;
          next_st.state       = amr_pkg::AMR_IDLE;
        end
      end
      amr_pkg::AMR_LOCKED: begin
        // Held until reset; no more automatic attempts
        next_st.state = amr_pkg::AMR_LOCKED;
      end
      default: next_st.state = amr_pkg::AMR_IDLE;
    endcase

    // Quiet-time clear of the retry counter
    if (st.state != amr_pkg::AMR_IDLE || all_faults != 7'h00) begin
      next_st.quiet_ticks = 13'h0000;
    end else if (tick) begin
      if (st.quiet_ticks == 13'(QUIET_TICKS - 1)) begin
        next_st.quiet_ticks = 13'h0000;
        next_st.retry_cnt   = amr_pkg::RST_RETRY_CNT;
      end else begin
        next_st.quiet_ticks = st.quiet_ticks + 13'h0001;
      end
    end

    // ****************************************
    // Cumulative run time, binary (hex) hours
    // ****************************************
    if (runtime_preset_we) begin
      next_st.runtime    = runtime_preset;
      next_st.run_ms_div = 30'h00000000;
    end else if (motor_running && tick) begin
      if (st.run_ms_div == 30'(HOUR_TICKS - 1)) begin
        next_st.run_ms_div = 30'h00000000;
        next_st.runtime    = st.runtime + 32'h0000_0001;
      end else begin
        next_st.run_ms_div = st.run_ms_div + 30'h00000001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st           <= '0;
      st.state     <= amr_pkg::AMR_IDLE;
      st.retry_cnt <= amr_pkg::RST_RETRY_CNT;
      st.runtime   <= amr_pkg::RST_RUNTIME;
    end else begin
      st <= next_st;
    end
  end

  // Terminal carries the minor fault only when assigned code 98
  assign dout_terminal = st.minor_fault_output
                       && (dout_assign_code == 8'(amr_pkg::OUTPUT_CODE_LALM));

  assign minor_fault_output   = st.minor_fault_output;
  assign tripped              = (st.state != amr_pkg::AMR_IDLE);
  assign trip_reset           = st.trip_reset;
  assign locked_alarm         = st.locked_alarm;
  assign feedback_break_alarm = st.feedback_break_alarm;
  assign retry_count          = st.retry_cnt;
  assign runtime_hours        = st.runtime;

endmodule : amr_alarm_retry
`default_nettype wire

// ### verification/amr_alarm_retry_asserts.sv
// Checker: port-level properties of the alarm and auto-retry block
`timescale 1ns/1ps
`default_nettype none
module amr_alarm_retry_asserts (
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire amr_pkg::amr_cfg_s cfg,
  input wire logic [6:0]        fault_in,
  input wire logic [7:0]        dout_assign_code,
  input wire logic              minor_fault_output,
  input wire logic              dout_terminal,
  input wire logic              tripped,
  input wire logic              trip_reset,
  input wire logic              locked_alarm,
  input wire logic              feedback_break_alarm,
  input wire logic [3:0]        retry_count
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Own wire-break alarm is a fault factor in bit 2 as well
  wire logic [6:0] af = fault_in | {4'h0, feedback_break_alarm, 2'h0};
  wire logic [6:0] lf = af & cfg.light_alarm_factor_mask;
  wire logic [6:0] hf = af & ~cfg.light_alarm_factor_mask;
  wire logic       sel = dout_assign_code == 8'h62;
  AST_DOUT: assert property (dout_terminal == (minor_fault_output && sel))
    else $error("terminal mismatch");
  AST_LIGHT: assert property (lf != 7'h00 |=> minor_fault_output)
    else $error("light alarm missing");
  AST_KEEP: assert property (!tripped && hf == 7'h00 |=> !tripped)
    else $error("trip without cause");
  AST_TRIP: assert property (!tripped && hf != 7'h00 |=> tripped)
    else $error("fault did not trip");
  AST_PULSE: assert property (trip_reset |=> !trip_reset)
    else $error("reset pulse too long");
  AST_LIMIT: assert property (trip_reset |-> retry_count <= cfg.retry_count_limit)
    else $error("retry past limit");
  AST_ZERO: assert property (cfg.retry_count_limit == 4'h0 |-> !trip_reset && !locked_alarm)
    else $error("retry while disabled");
  AST_LOCK: assert property (locked_alarm |=> locked_alarm)
    else $error("lock released");
  cover property (trip_reset);
  cover property ($rose(locked_alarm));
  cover property (dout_terminal);
endmodule : amr_alarm_retry_asserts
bind amr_alarm_retry amr_alarm_retry_asserts u_chk (.core_clk, .rst_n, .cfg, .fault_in,
  .dout_assign_code, .minor_fault_output, .dout_terminal, .tripped, .trip_reset,
  .locked_alarm, .feedback_break_alarm, .retry_count);
`default_nettype wire

// ### verification/amr_periph_watch.sv
// Partner: peripheral counting rising edges of the alarm terminal
`timescale 1ns/1ps
`default_nettype none
module amr_periph_watch (
  input  wire logic       core_clk,
  input  wire logic       dout_terminal,
  output logic      [7:0] alarm_seen
);
  logic prev = 1'b0;
  initial alarm_seen = 8'h00;
  always @(posedge core_clk) begin
    if (dout_terminal && !prev) alarm_seen <= alarm_seen + 8'h01;
    prev <= dout_terminal;
  end
endmodule : amr_periph_watch
`default_nettype wire

// ### verification/amr_alarm_retry_tb_top.sv
// Testbench: light alarm, auto-retry, wire break and run-time scenarios
`timescale 1ns/1ps
`default_nettype none
module amr_alarm_retry_tb_top;
  logic              core_clk = 1'b0, rst_n = 1'b0, cti = 1'b0, run = 1'b0, pwe = 1'b0;
  logic              minor_fault_output, dout_terminal, tripped, trip_reset, locked_alarm;
  logic              feedback_break_alarm;
  logic [6:0]        fault = 7'h00;
  logic [7:0]        lvl = 8'h00, code = 8'h00, seen;
  logic [3:0]        rc, expq[$];
  logic [31:0]       pre = 32'h0, runtime_hours;
  amr_pkg::amr_cfg_s cfg = '0;
  int                n_fail = 0, cmp_count = 0, n, r;
  initial forever #4 core_clk = ~core_clk;
  amr_alarm_retry #(.TICK_CYCLES(4), .QUIET_TICKS(10), .HOUR_TICKS(5)) u_dut (.core_clk,
    .rst_n, .cfg, .fault_in(fault), .current_input_terminal(cti), .current_level(lvl),
    .motor_running(run), .dout_assign_code(code), .runtime_preset_we(pwe),
    .runtime_preset(pre), .minor_fault_output, .dout_terminal, .tripped, .trip_reset,
    .locked_alarm, .feedback_break_alarm, .retry_count(rc), .runtime_hours);
  amr_periph_watch u_watch (.core_clk, .dout_terminal, .alarm_seen(seen));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask : cyc
  // Bounded wait; n keeps the cycle count for timing checks
  task automatic wt(ref logic s, input logic v, input int k);
    n = 0;
    while (s !== v) begin
      if (n++ == k) begin
        chk(1'b0, 1'b1);
        print_verdict();
      end
      @(posedge core_clk);
    end
  endtask : wt
  // Fresh reset per scenario so retry state never leaks across
  task automatic setup(input logic [6:0] lm, input logic [6:0] rm, input logic [3:0] lim);
    rst_n <= 1'b0;
    fault <= 7'h00;
    cfg <= '{lm, rm, lim, 13'h006, 8'h32, 10'h003};
    cyc(4);
    rst_n <= 1'b1;
    cyc(1);
  endtask : setup
  initial forever begin
    @(posedge core_clk);
    if (trip_reset === 1'b1) begin
      cyc(2);
      if (expq.size() == 0) chk(rc, 4'hF);
      else chk(rc, expq.pop_front());
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(32'hBE1B27FA));
    setup(7'h00, 7'h00, 4'h0);
    for (int b = 0; b < 7; b++) begin
      cfg.light_alarm_factor_mask <= 7'($urandom()) | (7'h01 << b);
      code <= b[0] ? 8'h62 : 8'($urandom_range(97, 0));
      fault <= 7'h01 << b;
      cyc(3);
      chk(minor_fault_output, 1'b1);
      chk(tripped, 1'b0);
      chk(dout_terminal, b[0]);
      fault <= 7'h00;
      cyc(2);
    end
    chk(seen, 8'h03);
    r = $urandom_range(6, 0);
    setup(7'h00, 7'h01 << r, 4'h2);
    expq = '{4'h1, 4'h2};
    fault <= 7'h01 << r;
    wt(tripped, 1'b1, 4);
    wt(trip_reset, 1'b1, 40);
    chk(n >= 21 && n <= 30, 1'b1);
    wt(locked_alarm, 1'b1, 60);
    cyc(8);
    chk(tripped, 1'b1);
    chk(expq.size(), 0);
    for (int k = 0; k < 2; k++) begin
      setup(7'h00, 7'h02, k ? 4'h3 : 4'h0);
      fault <= k ? 7'h04 : 7'h02;
      cyc(60);
      chk(tripped, 1'b1);
      chk(locked_alarm, k[0]);
    end
    setup(7'h00, 7'h01, 4'h3);
    expq = '{4'h1};
    fault <= 7'h01;
    cyc(2);
    fault <= 7'h00;
    wt(trip_reset, 1'b1, 40);
    cyc(25);
    chk(rc, 4'h1);
    cyc(35);
    chk(rc, 4'h0);
    for (int k = 0; k < 4; k++) begin
      setup(7'h04, 7'h00, 4'h0);
      cti <= (k != 1);
      lvl <= (k == 3) ? 8'h32 : 8'h31;
      if (k == 2) cfg.break_detect_time <= 10'h000;
      cyc(6);
      chk(feedback_break_alarm, 1'b0);
      cyc(20);
      chk(feedback_break_alarm, k == 0);
    end
    pre <= $urandom();
    pwe <= 1'b1;
    cyc(1);
    pwe <= 1'b0;
    run <= 1'b1;
    cyc(1);
    chk(runtime_hours, pre);
    cyc(24);
    chk(runtime_hours, pre + 32'h1);
    pre <= 32'h0;
    pwe <= 1'b1;
    run <= 1'b0;
    cyc(1);
    pwe <= 1'b0;
    cyc(1);
    chk(runtime_hours, 32'h0);
    print_verdict();
  end
endmodule : amr_alarm_retry_tb_top
`default_nettype wire
